/* ivs_defs.svh */
// ivs_defs.svh: offsets, bit positions, reset values and vector constants
// of the interrupt vector and special function register block.
// assumes: included by bare name; holds definitions only.
`ifndef IVS_DEFS_SVH
`define IVS_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define IVS_IDX_ENABLE_ONE  6'h00
`define IVS_IDX_ENABLE_TWO  6'h01
`define IVS_IDX_FLAG_ONE    6'h02
`define IVS_IDX_FLAG_TWO    6'h03

// bit positions in the enable and flag registers
`define IVS_BIT_WATCHDOG    0
`define IVS_BIT_OSC         1
`define IVS_BIT_POWER_ON    2
`define IVS_BIT_PIN_RESET   3
`define IVS_BIT_NMI_PIN     4
`define IVS_BIT_FLASH_ACCV  5

// reset values and implemented-bit masks
`define IVS_ENABLE_RST      8'h00
`define IVS_ENABLE_MASK     8'h33
`define IVS_FLAG_MASK       8'h1f

// vector words and priorities; vector = base + 2 * priority
`define IVS_VEC_BASE        16'hffc0
`define IVS_VEC_RESET       16'hfffe
`define IVS_BLANK_WORD      16'hffff
`define IVS_PRI_RESET       5'd31
`define IVS_PRI_NMI         5'd30
`define IVS_PRI_LOWEST_USED 5'd16

// address map seen by instruction fetch
`define IVS_SFR_PERIPH_TOP  16'h01ff
`define IVS_RAM_LO          16'h0200
`define IVS_RAM_HI          16'h02ff
`define IVS_INFO_LO         16'h1000
`define IVS_INFO_HI         16'h10ff
`define IVS_MAIN_LO         16'he000

`endif

/* ivs_pkg.sv */
// ivs_pkg.sv: types shared by the interrupt vector block and its bench.
// assumes: compiled before any file that names ivs_pkg.
package ivs_pkg;

  // arbiter states
  typedef enum logic [2:0] {
    ST_RESET_FETCH,
    ST_IDLE,
    ST_OFFER,
    ST_SERVICE,
    ST_SLEEP
  } ivs_state_t;

  // maskable request flags that live inside the peripheral modules
  typedef struct packed {
    logic       comparator_flag;
    logic       timer_cc0_flag;
    logic       timer_cc1_flag;
    logic       timer_cc2_flag;
    logic       timer_overflow_flag;
    logic       adc_flag;
    logic       serial_flag;
    logic [7:0] port2_pin_flags;
    logic [7:0] port1_pin_flags;
  } ivs_src_t;

  // clock and power control for the deepest sleep mode
  typedef struct packed {
    logic cpu_off;
    logic mclk_off;
    logic smclk_off;
    logic aclk_off;
    logic xtal_stop;
    logic dco_dc_off;
  } ivs_clk_ctl_t;

  // vector offered to the core
  typedef struct packed {
    logic [4:0]  priority_level;
    logic [15:0] vector_addr;
  } ivs_vec_t;

endpackage : ivs_pkg

/* ivs_core.sv */
// ivs_core.sv: interrupt arbitration, vector generation, reset generation
// and the low special function registers, as one module.
// assumes: one 20 MHz clock core_clk; rst_n is the power-on reset;
// classic wishbone master for register access; the core fetches vectors.
`timescale 1ns/10ps
`include "ivs_defs.svh"

module ivs_core (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output      logic [31:0]          wb_dat_o,
  output      logic                 wb_ack_o,
  input  wire logic                 pin_reset_evt,
  input  wire logic                 nmi_pin_evt,
  input  wire logic                 pin_nmi_mode,
  input  wire logic                 watchdog_expiry,
  input  wire logic                 watchdog_key_violation,
  input  wire logic                 watchdog_interval_mode,
  input  wire logic                 flash_key_violation,
  input  wire logic                 osc_fault,
  input  wire logic                 flash_access_violation_flag,
  input  wire logic                 gie,
  input  wire ivs_pkg::ivs_src_t    src,
  input  wire logic                 fetch_valid,
  input  wire logic [15:0]          fetch_addr,
  input  wire logic                 reset_vector_valid,
  input  wire logic [15:0]          reset_vector_word,
  input  wire logic                 irq_ack,
  input  wire logic                 irq_return,
  output      logic                 irq_req,
  output      ivs_pkg::ivs_vec_t    irq_out,
  output      logic                 power_up_clear,
  output      ivs_pkg::ivs_clk_ctl_t clk_ctl
);

  // byte address of a register index
  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
    return adr == {idx, 2'b00};
  endfunction : reg_hit

  // highest set request; bit i stands for priority 16 + i
  function automatic logic [4:0] pick_prio(input logic [14:0] r);
    logic [4:0] p;
    p = `IVS_PRI_LOWEST_USED;
    for (int i = 0; i < 15; i++) begin
      if (r[i]) p = 5'(i) + `IVS_PRI_LOWEST_USED;
    end
    return p;
  endfunction : pick_prio

  // instruction fetch is legal only from ram, information or main flash
  function automatic logic fetch_legal(input logic [15:0] a);
    return (a >= `IVS_RAM_LO && a <= `IVS_RAM_HI) ||
           (a >= `IVS_INFO_LO && a <= `IVS_INFO_HI) ||
           (a >= `IVS_MAIN_LO);
  endfunction : fetch_legal

  logic                 por_meta;
  logic                 por_n;
  logic                 power_up_clear_cause;
  logic                 flash_access_violation_enable;
  logic                 nmi_pin_enable;
  logic                 osc_fault_enable;
  logic                 watchdog_interval_enable;
  logic                 watchdog_flag;
  logic                 osc_fault_flag;
  logic                 power_on_flag;
  logic                 pin_reset_flag;
  logic                 nmi_pin_flag;
  logic                 wr_fire;
  logic                 wr_enable;
  logic                 wr_flag;
  logic [7:0]           wdat;
  logic [7:0]           enable_byte;
  logic [7:0]           flag_byte;
  logic [7:0]           rd_byte;
  logic                 nmi_any;
  logic [14:0]          req_vec;
  logic                 win_valid;
  logic [4:0]           win_prio;
  ivs_pkg::ivs_state_t  state;
  ivs_pkg::ivs_state_t  next_state;

  // power-on reset released through two flops; everything else uses por_n
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_meta <= 1'b0;
      por_n    <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_n    <= por_meta;
    end
  end

  // reset causes other than power-on; a pin event in nmi mode is not one
  assign power_up_clear_cause = (fetch_valid && !fetch_legal(fetch_addr)) ||
                                (pin_reset_evt && !pin_nmi_mode) ||
                                (watchdog_expiry && !watchdog_interval_mode) ||
                                watchdog_key_violation ||
                                flash_key_violation;

  // power-up clear is its cause registered: it rises one cycle after the cause and stays high as long as the cause
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      power_up_clear <= 1'b0;
    end else begin
      power_up_clear <= power_up_clear_cause;
    end
  end

  // classic wishbone slave: ack one cycle after request, dropped next cycle
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // writes land on the edge where the master sees ack; only lane 0 carries data
  assign wr_fire   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_enable = wr_fire && reg_hit(wb_adr_i, `IVS_IDX_ENABLE_ONE);
  assign wr_flag   = wr_fire && reg_hit(wb_adr_i, `IVS_IDX_FLAG_ONE);
  assign wdat      = wb_dat_i[7:0];

  // absent bits are not stored and read as zero
  assign enable_byte = {2'b00, flash_access_violation_enable, nmi_pin_enable,
                        2'b00, osc_fault_enable, watchdog_interval_enable};
  assign flag_byte   = {3'b000, nmi_pin_flag, pin_reset_flag, power_on_flag,
                        osc_fault_flag, watchdog_flag};

  // second enable and flag registers have no bits; unmapped reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(wb_adr_i, `IVS_IDX_ENABLE_ONE)) begin
      rd_byte = enable_byte;
    end else if (reg_hit(wb_adr_i, `IVS_IDX_FLAG_ONE)) begin
      rd_byte = flag_byte;
    end
  end

  // read data captured as ack rises so it stands while ack is high
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // enable register: cleared by power-on and by every power-up clear
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      flash_access_violation_enable <= 1'b0;
      nmi_pin_enable                <= 1'b0;
      osc_fault_enable              <= 1'b0;
      watchdog_interval_enable      <= 1'b0;
    end else if (power_up_clear) begin
      flash_access_violation_enable <= 1'(`IVS_ENABLE_RST >> `IVS_BIT_FLASH_ACCV);
      nmi_pin_enable                <= 1'b0;
      osc_fault_enable              <= 1'b0;
      watchdog_interval_enable      <= 1'b0;
    end else if (wr_enable) begin
      flash_access_violation_enable <= wdat[`IVS_BIT_FLASH_ACCV];
      nmi_pin_enable                <= wdat[`IVS_BIT_NMI_PIN];
      osc_fault_enable              <= wdat[`IVS_BIT_OSC];
      watchdog_interval_enable      <= wdat[`IVS_BIT_WATCHDOG];
    end
  end

  // flags touched by power-up clear; a hardware set beats a software clear
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      osc_fault_flag <= 1'b1;
      nmi_pin_flag   <= 1'b0;
    end else if (power_up_clear) begin
      osc_fault_flag <= 1'b1;
      nmi_pin_flag   <= 1'b0;
    end else begin
      osc_fault_flag <= (wr_flag ? wdat[`IVS_BIT_OSC] : osc_fault_flag) | osc_fault;
      nmi_pin_flag   <= (wr_flag ? wdat[`IVS_BIT_NMI_PIN] : nmi_pin_flag) |
                        (nmi_pin_evt && pin_nmi_mode);
    end
  end

  // power-on-only flags: power-up clear leaves them alone so software
  // can tell after the restart which cause brought the device down
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      power_on_flag  <= 1'b1;
      pin_reset_flag <= 1'b0;
      watchdog_flag  <= 1'b0;
    end else begin
      power_on_flag  <= wr_flag ? wdat[`IVS_BIT_POWER_ON] : power_on_flag;
      pin_reset_flag <= (wr_flag ? wdat[`IVS_BIT_PIN_RESET] : pin_reset_flag) |
                        (pin_reset_evt && !pin_nmi_mode);
      watchdog_flag  <= (wr_flag ? wdat[`IVS_BIT_WATCHDOG] : watchdog_flag) |
                        watchdog_expiry | watchdog_key_violation;
    end
  end

  // non-maskable group ignores the global enable
  assign nmi_any = (nmi_pin_flag && nmi_pin_enable) ||
                   (osc_fault_flag && osc_fault_enable) ||
                   (flash_access_violation_flag && flash_access_violation_enable);

  // request map, bit i = priority 16 + i; peripheral flags come in as levels
  // from their own modules, this block stores none of them
  always_comb begin
    req_vec     = 15'h0000;
    req_vec[14] = nmi_any;
    req_vec[11] = gie && src.comparator_flag;
    req_vec[10] = gie && watchdog_flag && watchdog_interval_enable &&
                  watchdog_interval_mode;
    req_vec[9]  = gie && src.timer_cc0_flag;
    req_vec[8]  = gie && (src.timer_cc1_flag || src.timer_cc2_flag ||
                          src.timer_overflow_flag);
    req_vec[5]  = gie && src.adc_flag;
    req_vec[4]  = gie && src.serial_flag;
    req_vec[3]  = gie && (|src.port2_pin_flags);
    req_vec[2]  = gie && (|src.port1_pin_flags);
  end

  // priorities below 16 have no bit, so they can never win
  assign win_valid = |req_vec;
  assign win_prio  = pick_prio(req_vec);

  // arbiter: reset fetch first, then offer / service / return
  always_comb begin
    next_state = state;
    if (power_up_clear) begin
      next_state = ivs_pkg::ST_RESET_FETCH;
    end else begin
      case (state)
        ivs_pkg::ST_RESET_FETCH: begin
          if (reset_vector_valid) begin
            if (reset_vector_word == `IVS_BLANK_WORD) begin
              next_state = ivs_pkg::ST_SLEEP;
            end else begin
              next_state = ivs_pkg::ST_IDLE;
            end
          end
        end
        ivs_pkg::ST_IDLE: begin
          if (win_valid) next_state = ivs_pkg::ST_OFFER;
        end
        ivs_pkg::ST_OFFER: begin
          if (irq_ack) begin
            next_state = ivs_pkg::ST_SERVICE;
          end else if (!win_valid) begin
            next_state = ivs_pkg::ST_IDLE;
          end
        end
        ivs_pkg::ST_SERVICE: begin
          if (irq_return) next_state = ivs_pkg::ST_IDLE;
        end
        ivs_pkg::ST_SLEEP: begin
          if (win_valid) next_state = ivs_pkg::ST_OFFER;
        end
        default: next_state = ivs_pkg::ST_IDLE;
      endcase
    end
  end

  // power-on starts at the reset vector fetch
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      state <= ivs_pkg::ST_RESET_FETCH;
    end else begin
      state <= next_state;
    end
  end

  // handshake from the state; no nesting, service holds until return
  assign irq_req = (state == ivs_pkg::ST_OFFER) || (state == ivs_pkg::ST_RESET_FETCH);

  // vector follows the winner while offered, frozen once taken
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      irq_out.priority_level <= `IVS_PRI_RESET;
      irq_out.vector_addr    <= `IVS_VEC_RESET;
    end else if (next_state == ivs_pkg::ST_RESET_FETCH) begin
      irq_out.priority_level <= `IVS_PRI_RESET;
      irq_out.vector_addr    <= `IVS_VEC_RESET;
    end else if (next_state == ivs_pkg::ST_OFFER) begin
      irq_out.priority_level <= win_prio;
      irq_out.vector_addr    <= `IVS_VEC_BASE + {10'h000, win_prio, 1'b0};
    end
  end

  // deepest sleep: cpu, all clocks, crystal and dc generator off together
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      clk_ctl <= '0;
    end else begin
      clk_ctl.cpu_off    <= next_state == ivs_pkg::ST_SLEEP;
      clk_ctl.mclk_off   <= next_state == ivs_pkg::ST_SLEEP;
      clk_ctl.smclk_off  <= next_state == ivs_pkg::ST_SLEEP;
      clk_ctl.aclk_off   <= next_state == ivs_pkg::ST_SLEEP;
      clk_ctl.xtal_stop  <= next_state == ivs_pkg::ST_SLEEP;
      clk_ctl.dco_dc_off <= next_state == ivs_pkg::ST_SLEEP;
    end
  end

  // checks on the block's outputs and internal state
  default clocking ast_clk @(posedge core_clk); endclocking
  default disable iff (!por_n);

  AST_VEC_MAP: assert property (
    irq_req |-> irq_out.vector_addr == `IVS_VEC_BASE + {10'h000, irq_out.priority_level, 1'b0})
    else $error("vector word does not match priority");

  AST_BLANK_SLEEP: assert property (
    (state == ivs_pkg::ST_RESET_FETCH) && reset_vector_valid && !power_up_clear &&
    (reset_vector_word == `IVS_BLANK_WORD) |=> clk_ctl.cpu_off && clk_ctl.xtal_stop)
    else $error("blank reset vector did not enter deepest sleep");

  AST_CLR_RESET_VEC: assert property (power_up_clear |=> irq_req &&
    irq_out.priority_level == 5'd31 && irq_out.vector_addr == 16'hfffe)
    else $error("reset vector not offered after power-up clear");

  AST_ILLEGAL_FETCH: assert property (
    fetch_valid && fetch_addr <= `IVS_SFR_PERIPH_TOP |=> power_up_clear)
    else $error("fetch from register space did not reset");

  AST_NMI_PRIO: assert property (nmi_any && state == ivs_pkg::ST_IDLE &&
    !power_up_clear |=> irq_req && irq_out.priority_level == 5'd30)
    else $error("nmi group not offered at priority 30");

  AST_NMI_NO_GIE: assert property (nmi_pin_flag && nmi_pin_enable && !gie &&
    state == ivs_pkg::ST_IDLE && !power_up_clear |=> irq_req)
    else $error("nmi pin request blocked by global enable");

  AST_LOW_NEVER: assert property (
    irq_req |-> irq_out.priority_level >= `IVS_PRI_LOWEST_USED)
    else $error("low priority vector offered");

  AST_CLR_ENABLES: assert property (
    power_up_clear |=> enable_byte == 8'h00 && osc_fault_flag)
    else $error("enables not cleared by power-up clear");

  AST_WDT_MODE: assert property (
    !watchdog_interval_mode |-> !req_vec[10])
    else $error("watchdog interrupt in reset mode");

  AST_CLR_FLAGS: assert property (power_up_clear |=> osc_fault_flag &&
    !nmi_pin_flag && power_on_flag == $past(power_on_flag))
    else $error("flag values wrong after power-up clear");

  AST_PIN_RESET_FLAG: assert property (
    pin_reset_evt && !pin_nmi_mode |=> pin_reset_flag ##1 state == ivs_pkg::ST_RESET_FETCH)
    else $error("pin reset not flagged or not restarted");

  AST_NMI_FLAG: assert property (
    nmi_pin_evt && pin_nmi_mode && !power_up_clear |=> nmi_pin_flag)
    else $error("nmi pin event not flagged");

  AST_WDT_FLAG: assert property (
    watchdog_expiry || watchdog_key_violation |=> watchdog_flag)
    else $error("watchdog event not flagged");

  AST_SERVICE_HOLD: assert property (
    state == ivs_pkg::ST_SERVICE && !irq_return && !power_up_clear |=> !irq_req [*1])
    else $error("new request offered before return");

endmodule : ivs_core

/* ivs_core_model.sv */
// ivs_core_model.sv: processor core as seen at the vector port of ivs_core.
// assumes: same core_clk as ivs_core; outputs change just after the rising edge.
`timescale 1ns/10ps
module ivs_core_model (
  input  wire logic              core_clk,
  input  wire logic              irq_req,
  input  wire ivs_pkg::ivs_vec_t irq_out,
  input  wire logic              blank_flash,
  input  wire logic              slow,
  output      logic              reset_vector_valid,
  output      logic [15:0]       reset_vector_word,
  output      logic              irq_ack,
  output      logic              irq_return,
  output      ivs_pkg::ivs_vec_t last_vec,
  output      logic [7:0]        n_taken
);
  logic [3:0] wait_cnt;
  logic [3:0] svc_cnt;
  logic       in_svc;

  // start idle so no pulse is ever unknown
  initial begin
    {reset_vector_valid, irq_ack, irq_return, in_svc} = 4'h0;
    {wait_cnt, svc_cnt, n_taken} = 16'h0000;
    reset_vector_word = 16'he000;
    last_vec = '0;
  end

  // reset fetch: report the top word every other cycle; blank flash reads all ones
  always @(posedge core_clk) begin
    reset_vector_valid <= irq_req && irq_out.vector_addr == 16'hfffe && !reset_vector_valid;
    reset_vector_word  <= blank_flash ? 16'hffff : 16'he000;
  end

  // take an offered vector after a short or long pause, return after twelve cycles
  always @(posedge core_clk) begin
    irq_ack    <= 1'b0;
    irq_return <= 1'b0;
    if (in_svc) begin
      svc_cnt <= svc_cnt + 4'h1;
      if (svc_cnt == 4'hb) begin
        in_svc     <= 1'b0;
        irq_return <= 1'b1;
      end
    end else if (irq_req && irq_out.vector_addr != 16'hfffe && !irq_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= (slow ? 4'h4 : 4'h1)) begin
        irq_ack  <= 1'b1;
        in_svc   <= 1'b1;
        svc_cnt  <= 4'h0;
        wait_cnt <= 4'h0;
        last_vec <= irq_out;
        n_taken  <= n_taken + 8'h01;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule : ivs_core_model

/* ivs_core_tb.sv */
// ivs_core_tb.sv: self-checking bench for ivs_core over wishbone and the vector port.
// assumes: ivs_pkg and ivs_core_model compiled first; 20 MHz clock.
`timescale 1ns/10ps
module ivs_core_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, q;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, n_mismatch = 0, checks_done = 0, n_clr = 0, exp_clr = 0;
  logic wb_ack_o, irq_req, power_up_clear, rvv, iack, iret, blank = 1'b0, slow = 1'b0;
  logic gie = 1'b0, osc_fault = 1'b0, wdt_key = 1'b0, fav = 1'b0;
  logic pin_reset_evt = 1'b0, nmi_pin_evt = 1'b0, pin_nmi_mode = 1'b0, watchdog_expiry = 1'b0;
  logic wdt_interval = 1'b0, flash_key_violation = 1'b0, fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'he000, rvw;
  logic [7:0] n_taken;
  ivs_pkg::ivs_src_t src = '0;
  ivs_pkg::ivs_vec_t irq_out, last_vec;
  ivs_pkg::ivs_clk_ctl_t clk_ctl;
  int cycles = 0;

  ivs_core ivs_core_i (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_reset_evt(pin_reset_evt), .nmi_pin_evt(nmi_pin_evt),
    .pin_nmi_mode(pin_nmi_mode), .watchdog_expiry(watchdog_expiry),
    .watchdog_key_violation(wdt_key), .watchdog_interval_mode(wdt_interval),
    .flash_key_violation(flash_key_violation), .osc_fault(osc_fault),
    .flash_access_violation_flag(fav), .gie(gie), .src(src), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .reset_vector_valid(rvv), .reset_vector_word(rvw),
    .irq_ack(iack), .irq_return(iret), .irq_req(irq_req), .irq_out(irq_out),
    .power_up_clear(power_up_clear), .clk_ctl(clk_ctl));

  ivs_core_model ivs_core_model_i (.core_clk(core_clk), .irq_req(irq_req), .irq_out(irq_out),
    .blank_flash(blank), .slow(slow), .reset_vector_valid(rvv), .reset_vector_word(rvw),
    .irq_ack(iack), .irq_return(iret), .last_vec(last_vec), .n_taken(n_taken));

  // 50 ns period
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // count power-up clears and cut a hang short
  always @(posedge core_clk) begin
    if (power_up_clear === 1'b1) n_clr <= n_clr + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'h1, 24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    if (n >= 50) chk("wb ack", 32'h0, 32'h1);
    {cyc, stb} <= 2'b00;
  endtask : wb

  // one-cycle event: 0 pin reset, 1 nmi pin, 2 watchdog, 3 flash key, 5 osc fault,
  // 6 watchdog key violation, else fetch
  task automatic pulse(input int k);
    @(posedge core_clk);
    case (k)
      0: pin_reset_evt <= 1'b1;
      1: nmi_pin_evt <= 1'b1;
      2: watchdog_expiry <= 1'b1;
      3: flash_key_violation <= 1'b1;
      5: osc_fault <= 1'b1;
      6: wdt_key <= 1'b1;
      default: fetch_valid <= 1'b1;
    endcase
    @(posedge core_clk);
    {pin_reset_evt, nmi_pin_evt, watchdog_expiry, flash_key_violation, fetch_valid,
     osc_fault, wdt_key} <= 7'h00;
  endtask : pulse

  // wait for the core model to take the next vector, then compare it
  task automatic serve(input logic [4:0] p, input logic [15:0] v);
    int n;
    logic [7:0] t0;
    n = 0;
    t0 = n_taken;
    while (n_taken === t0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("priority", last_vec.priority_level, p);
    chk("vector", last_vec.vector_addr, v);
  endtask : serve

  // after a reset cause: one more power-up clear, then the flag register
  task automatic settle(input logic [7:0] f);
    exp_clr = exp_clr + 1;
    repeat (8) @(posedge core_clk);
    chk("clear count", n_clr, exp_clr);
    wb(1'b0, 8'h08, 8'h00);
    chk("flag_one", q, f);
  endtask : settle

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    wb(1'b0, 8'h00, 8'h00); chk("enable_one", q, 8'h00);
    wb(1'b0, 8'h08, 8'h00); chk("flag_one", q, 8'h06);
    wb(1'b0, 8'h04, 8'h00); chk("enable_two", q, 8'h00);
    wb(1'b0, 8'h0c, 8'h00); chk("flag_two", q, 8'h00);
    wb(1'b0, 8'h40, 8'h00); chk("unmapped", q, 8'h00);
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b0, 8'h08, 8'h00); chk("flag_one", q, 8'h00);
    wb(1'b1, 8'h00, 8'hff);
    wb(1'b0, 8'h00, 8'h00); chk("enable_one", q, 8'h33);
    pin_nmi_mode <= 1'b1;
    pulse(1); serve(5'd30, 16'hfffc);
    wb(1'b0, 8'h08, 8'h00); chk("flag_one", q, 8'h10);
    wb(1'b1, 8'h08, 8'h00);
    // flash access violation is a level held by the flash module
    fav <= 1'b1;
    serve(5'd30, 16'hfffc);
    fav <= 1'b0;
    // maskable flags stay parked while the global enable is low
    src.port1_pin_flags <= 8'h01;
    repeat (16) @(posedge core_clk);
    chk("irq_req", irq_req, 1'b0);
    slow <= 1'b1;
    {src.timer_cc0_flag, src.timer_cc1_flag, src.port2_pin_flags} <= {2'b11, 8'h08};
    {src.comparator_flag, src.serial_flag} <= 2'b11;
    gie <= 1'b1;
    serve(5'd27, 16'hfff6); src.comparator_flag <= 1'b0;
    serve(5'd25, 16'hfff2); src.timer_cc0_flag <= 1'b0;
    serve(5'd24, 16'hfff0); src.timer_cc1_flag <= 1'b0;
    serve(5'd20, 16'hffe8); src.serial_flag <= 1'b0;
    serve(5'd19, 16'hffe6); src.port2_pin_flags <= 8'h00;
    serve(5'd18, 16'hffe4); src.port1_pin_flags <= 8'h00;
    wdt_interval <= 1'b1;
    pulse(2); serve(5'd26, 16'hfff4);
    wb(1'b1, 8'h08, 8'h00);
    repeat (16) @(posedge core_clk);
    {slow, gie, wdt_interval} <= 3'b000;
    pulse(4); repeat (4) @(posedge core_clk);
    chk("clear count", n_clr, 32'h0);
    fetch_addr <= 16'h0100;
    pulse(4); settle(8'h02);
    wb(1'b0, 8'h00, 8'h00); chk("enable_one", q, 8'h00);
    pin_nmi_mode <= 1'b0;
    pulse(0); settle(8'h0a);
    pulse(2); settle(8'h0b);
    wb(1'b1, 8'h08, 8'h00);
    pulse(5); wb(1'b0, 8'h08, 8'h00); chk("flag_one", q, 8'h02);
    pulse(6); settle(8'h03);
    blank <= 1'b1;
    pulse(3); repeat (8) @(posedge core_clk);
    chk("clk_ctl", clk_ctl, 6'h3f);
    src.port1_pin_flags <= 8'h80;
    gie <= 1'b1;
    serve(5'd18, 16'hffe4);
    chk("clk_ctl", clk_ctl, 6'h00);
    tally_and_finish();
  end
endmodule : ivs_core_tb
